// ### design/pcfp_pkg.sv
// Shared constants and carrier types for the pad configuration and fast port block
package pcfp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Port geometry
   localparam int unsigned LINES = 32;
   localparam int unsigned DRV_W = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Local bus byte addresses of the fast port registers
   localparam logic [31:0] ADDR_OE_WRITE = 32'h4000_0340;
   localparam logic [31:0] ADDR_OE_SET = 32'h4000_0344;
   localparam logic [31:0] ADDR_OE_CLEAR = 32'h4000_0348;
   localparam logic [31:0] ADDR_OE_TOGGLE = 32'h4000_034c;
   localparam logic [31:0] ADDR_OV_WRITE = 32'h4000_0350;
   localparam logic [31:0] ADDR_OV_SET = 32'h4000_0354;
   localparam logic [31:0] ADDR_OV_CLEAR = 32'h4000_0358;
   localparam logic [31:0] ADDR_OV_TOGGLE = 32'h4000_035c;
   localparam logic [31:0] ADDR_PIN_LEVEL = 32'h4000_0360;

   // Alias select lives in address bits 3:2 inside each group of four
   localparam int unsigned ALIAS_LSB = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] OE_RESET = 32'h0000_0000;
   localparam logic [31:0] OV_RESET = 32'h0000_0000;
   localparam logic [DRV_W-1:0] DRIVE_LOWEST = 2'h0;
   localparam logic SCAN_EN_RESET = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Lines that carry the boundary-scan port when it is enabled
   localparam logic [4:0] LINE_TCK = 5'h00;
   localparam logic [4:0] LINE_TMS = 5'h01;
   localparam logic [4:0] LINE_TDI = 5'h02;
   localparam logic [4:0] LINE_TDO = 5'h03;

   ////////////////////////////////////////////////////////////////////////////
   // Alias modes of a write
   typedef enum logic [1:0] {
      PCFP_AL_WRITE = 2'h0,
      PCFP_AL_SET = 2'h1,
      PCFP_AL_CLEAR = 2'h2,
      PCFP_AL_TOGGLE = 2'h3
   } pcfp_alias_t;

   // Per-line programmed pad settings
   typedef struct packed {
      logic pull_up;
      logic pull_down;
      logic [DRV_W-1:0] drive;
   } pcfp_line_cfg_t;

   // Boundary-scan override for one line
   typedef struct packed {
      logic active;
      logic oe;
      logic out;
      logic pull_up;
   } pcfp_scan_ovr_t;

   // Everything the pad itself is told
   typedef struct packed {
      logic oe;
      logic out;
      logic pull_up;
      logic pull_down;
      logic [DRV_W-1:0] drive;
      logic slew_limit;
      logic filter_en;
   } pcfp_pad_ctrl_t;

endpackage : pcfp_pkg

// ### design/pcfp_sync.sv
// Three-stage synchroniser whose output moves only when stages two and three agree
`timescale 1ns/10ps
module pcfp_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Asynchronous level in, settled level out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // Stage one feeds stage two only, nothing else looks at it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A bit changes only once two settled stages agree, which rejects a lone glitch
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         level_out <= '0;
      end else begin
         level_out <= (s2_reg & s3_reg) | (level_out & (s2_reg | s3_reg));
      end
   end

endmodule : pcfp_sync

// ### design/pcfp_pad_cell.sv
// Function priority and pull arbitration for one I/O line
`timescale 1ns/10ps
module pcfp_pad_cell (
   // Programmed settings and plain port control
   input wire pcfp_pkg::pcfp_line_cfg_t cfg,
   input wire logic gpio_oe,
   input wire logic gpio_out,
   // Peripheral function
   input wire logic periph_sel,
   input wire logic periph_oe,
   input wire logic periph_out,
   // Two-wire serial function
   input wire logic twi_sel,
   input wire logic twi_drive_low,
   // Analog function and scan override
   input wire logic analog_sel,
   input wire pcfp_pkg::pcfp_scan_ovr_t scan,
   input wire logic reset_pull_up,
   // Resulting pad control
   output pcfp_pkg::pcfp_pad_ctrl_t ctrl
);

   // Scan beats analog, analog beats serial, serial beats peripheral and plain port
   always_comb begin
      ctrl = '0;
      ctrl.drive = cfg.drive;
      ctrl.pull_up = cfg.pull_up;
      ctrl.pull_down = cfg.pull_down;
      if (scan.active) begin
         ctrl.oe = scan.oe;
         ctrl.out = scan.out;
         ctrl.pull_up = scan.pull_up;
         ctrl.pull_down = 1'b0;
      end else if (analog_sel) begin
         ctrl.pull_up = 1'b0;
         ctrl.pull_down = 1'b0;
      end else if (twi_sel) begin
         // Open drain: drive only a low, let the bus pull-up make the high
         ctrl.oe = twi_drive_low;
         ctrl.out = 1'b0;
         ctrl.slew_limit = 1'b1;
         ctrl.filter_en = 1'b1;
      end else if (periph_sel) begin
         ctrl.oe = periph_oe;
         ctrl.out = periph_out;
      end else begin
         ctrl.oe = gpio_oe;
         ctrl.out = gpio_out;
      end
      // Held pull-up wins over every setting while reset lasts
      if (reset_pull_up) begin
         ctrl.pull_up = 1'b1;
         ctrl.pull_down = 1'b0;
      end
   end

endmodule : pcfp_pad_cell

// ### design/pcfp_port.sv
// Pad configuration, boundary-scan strap and local-bus fast port for one 32-line port
`timescale 1ns/10ps
module pcfp_port (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // External reset pin level, sampled only
   input wire logic reset_pin_n,
   // Local bus
   input wire logic lb_req,
   input wire logic lb_write,
   input wire logic [31:0] lb_addr,
   input wire logic [31:0] lb_wdata,
   output logic lb_ack,
   output logic lb_err,
   output logic [31:0] lb_rdata,
   // Port controller pad programming
   input wire logic cfg_we,
   input wire logic [4:0] cfg_line,
   input wire pcfp_pkg::pcfp_line_cfg_t cfg_wdata,
   output pcfp_pkg::pcfp_line_cfg_t cfg_rdata,
   // Function selection per line
   input wire logic [31:0] periph_sel,
   input wire logic [31:0] periph_oe,
   input wire logic [31:0] periph_out,
   input wire logic [31:0] twi_sel,
   input wire logic [31:0] twi_drive_low,
   input wire logic [31:0] analog_sel,
   // Boundary-scan tap side
   input wire logic scan_tdo,
   input wire logic scan_tdo_en,
   output logic scan_enable,
   output logic scan_tck,
   output logic scan_tms,
   output logic scan_tdi,
   // Pads
   input wire logic [31:0] pad_in,
   output logic [31:0] pad_oe,
   output logic [31:0] pad_out,
   output logic [31:0] pad_pull_up,
   output logic [31:0] pad_pull_down,
   output logic [63:0] pad_drive,
   output logic [31:0] pad_slew_limit,
   output logic [31:0] pad_filter_en
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Fast port state
   logic [31:0] oe_reg;
   logic [31:0] ov_reg;
   logic [31:0] oe_next;
   logic [31:0] ov_next;

   // Settled input levels
   logic [31:0] pin_level;
   logic reset_pin_level;

   // Strap capture
   logic strap_pending_reg;
   logic scan_en_reg;

   // Per-line programmed settings
   pcfp_pkg::pcfp_line_cfg_t line_cfg_reg [pcfp_pkg::LINES];

   // Bus decode
   logic hit_oe;
   logic hit_ov;
   logic hit_pin;
   logic hit_any;
   pcfp_pkg::pcfp_alias_t alias_mode;

   // Pad controls before the output flops
   pcfp_pkg::pcfp_pad_ctrl_t ctrl [pcfp_pkg::LINES];

   ////////////////////////////////////////////////////////////////////////////
   // Alias arithmetic shared by both writable controls

   // Only bits written as one are touched by set, clear and toggle
   function automatic logic [31:0] pcfp_apply(
      input logic [31:0] cur,
      input logic [31:0] wdata,
      input pcfp_pkg::pcfp_alias_t mode
   );
      logic [31:0] res;
      res = cur;
      unique case (mode)
         pcfp_pkg::PCFP_AL_WRITE: res = wdata;
         pcfp_pkg::PCFP_AL_SET: res = cur | wdata;
         pcfp_pkg::PCFP_AL_CLEAR: res = cur & ~wdata;
         pcfp_pkg::PCFP_AL_TOGGLE: res = cur ^ wdata;
      endcase
      return res;
   endfunction : pcfp_apply

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   // Pad levels arrive from the board, unrelated to clk_sys
   pcfp_sync #(
      .W(32)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(pad_in),
      .level_out(pin_level)
   );

   // The reset pin is only ever read here, never driven
   pcfp_sync #(
      .W(1)
   ) u_rst_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(reset_pin_n),
      .level_out(reset_pin_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Boundary-scan strap

   // Pending stays up while the pin is held low and for the first clocks after
   // system reset; the strap is caught on the cycle the settled pin reads high.
   // The settled pin resets to low, so a power-on with the pin already high
   // still passes through four pending cycles, the synchroniser delay, before sampling.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strap_pending_reg <= 1'b1;
      end else if (!reset_pin_level) begin
         strap_pending_reg <= 1'b1;
      end else begin
         strap_pending_reg <= 1'b0;
      end
   end

   // Test clock low at the release edge turns the scan port on
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scan_en_reg <= pcfp_pkg::SCAN_EN_RESET;
      end else if (strap_pending_reg && reset_pin_level) begin
         scan_en_reg <= ~pin_level[pcfp_pkg::LINE_TCK];
      end else if (!reset_pin_level) begin
         scan_en_reg <= pcfp_pkg::SCAN_EN_RESET;
      end
   end

   assign scan_enable = scan_en_reg;

   // Tap sees settled pad levels; idle high when the port is off
   assign scan_tck = scan_en_reg ? pin_level[pcfp_pkg::LINE_TCK] : 1'b1;
   assign scan_tms = scan_en_reg ? pin_level[pcfp_pkg::LINE_TMS] : 1'b1;
   assign scan_tdi = scan_en_reg ? pin_level[pcfp_pkg::LINE_TDI] : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Local bus decode

   // Address bits 3:2 pick the alias; the group is matched on bits 31:4, bits 1:0 are ignored; the pin level word is matched on all 32 bits
   assign alias_mode = pcfp_pkg::pcfp_alias_t'(lb_addr[pcfp_pkg::ALIAS_LSB +: 2]);
   assign hit_oe = (lb_addr[31:4] == pcfp_pkg::ADDR_OE_WRITE[31:4]);
   assign hit_ov = (lb_addr[31:4] == pcfp_pkg::ADDR_OV_WRITE[31:4]);
   assign hit_pin = (lb_addr == pcfp_pkg::ADDR_PIN_LEVEL);
   assign hit_any = hit_oe | hit_ov | hit_pin;

   // Next values of the two writable controls
   always_comb begin
      oe_next = oe_reg;
      ov_next = ov_reg;
      if (lb_req && lb_write && hit_oe) begin
         oe_next = pcfp_apply(oe_reg, lb_wdata, alias_mode);
      end
      if (lb_req && lb_write && hit_ov) begin
         ov_next = pcfp_apply(ov_reg, lb_wdata, alias_mode);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fast port registers

   // Lines come up as inputs, so enable and value both clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         oe_reg <= pcfp_pkg::OE_RESET;
         ov_reg <= pcfp_pkg::OV_RESET;
      end else begin
         oe_reg <= oe_next;
         ov_reg <= ov_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local bus answer

   // Every request is answered one cycle later. Reading a write-only alias
   // returns zero without error, since the hardware keeps no readable copy
   // there; writing the pin level register or any unmapped word errs.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lb_ack <= 1'b0;
         lb_err <= 1'b0;
      end else begin
         lb_ack <= lb_req;
         lb_err <= lb_req && (!hit_any || (lb_write && hit_pin));
      end
   end

   // Read data holds pin levels for the readback word, zero elsewhere
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lb_rdata <= '0;
      end else if (lb_req && !lb_write) begin
         lb_rdata <= hit_pin ? pin_level : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-line pad settings from the port controller

   // Programmed readback is combinational so the controller sees it at once
   assign cfg_rdata = line_cfg_reg[cfg_line];

   generate
      for (genvar i = 0; i < pcfp_pkg::LINES; i++) begin : g_line
         localparam logic [4:0] IDX = 5'(i);
         pcfp_pkg::pcfp_scan_ovr_t scan_ovr;
         logic rst_pu;

         // One writable entry per line, defaulting to pulls off and weakest drive
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               line_cfg_reg[i].pull_up <= 1'b0;
               line_cfg_reg[i].pull_down <= 1'b0;
               line_cfg_reg[i].drive <= pcfp_pkg::DRIVE_LOWEST;
            end else if (cfg_we && (cfg_line == IDX)) begin
               line_cfg_reg[i] <= cfg_wdata;
            end
         end

         // Scan lines: inputs pulled up, data out driven without pull
         always_comb begin
            scan_ovr = '0;
            if (scan_en_reg) begin
               if (IDX == pcfp_pkg::LINE_TDO) begin
                  scan_ovr.active = 1'b1;
                  scan_ovr.oe = scan_tdo_en;
                  scan_ovr.out = scan_tdo;
                  scan_ovr.pull_up = 1'b0;
               end else if ((IDX == pcfp_pkg::LINE_TCK) || (IDX == pcfp_pkg::LINE_TMS)
                            || (IDX == pcfp_pkg::LINE_TDI)) begin
                  scan_ovr.active = 1'b1;
                  scan_ovr.pull_up = 1'b1;
               end
            end
         end

         // Test clock pull-up during system reset or pin reset
         assign rst_pu = (IDX == pcfp_pkg::LINE_TCK) && strap_pending_reg;

         pcfp_pad_cell u_cell (
            .cfg(line_cfg_reg[i]),
            .gpio_oe(oe_reg[i]),
            .gpio_out(ov_reg[i]),
            .periph_sel(periph_sel[i]),
            .periph_oe(periph_oe[i]),
            .periph_out(periph_out[i]),
            .twi_sel(twi_sel[i]),
            .twi_drive_low(twi_drive_low[i]),
            .analog_sel(analog_sel[i]),
            .scan(scan_ovr),
            .reset_pull_up(rst_pu),
            .ctrl(ctrl[i])
         );

         // Pad controls leave through flops; reset shows input, TCK pulled up
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               pad_oe[i] <= 1'b0;
               pad_out[i] <= 1'b0;
               pad_pull_up[i] <= (IDX == pcfp_pkg::LINE_TCK);
               pad_pull_down[i] <= 1'b0;
               pad_drive[i*2 +: 2] <= pcfp_pkg::DRIVE_LOWEST;
               pad_slew_limit[i] <= 1'b0;
               pad_filter_en[i] <= 1'b0;
            end else begin
               pad_oe[i] <= ctrl[i].oe;
               pad_out[i] <= ctrl[i].out;
               pad_pull_up[i] <= ctrl[i].pull_up;
               pad_pull_down[i] <= ctrl[i].pull_down;
               pad_drive[i*2 +: 2] <= ctrl[i].drive;
               pad_slew_limit[i] <= ctrl[i].slew_limit;
               pad_filter_en[i] <= ctrl[i].filter_en;
            end
         end
      end
   endgenerate

endmodule : pcfp_port

// ### tb/pcfp_board.sv
// Board model that resolves every pin from device drivers, board drivers and pulls
`timescale 1ns/10ps
module pcfp_board (
   // Clock for the wander pattern
   input wire logic clk_sys,
   // Device side of each pad
   input wire logic [31:0] pad_oe,
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_pull_up,
   input wire logic [31:0] pad_pull_down,
   // Board drivers
   input wire logic [31:0] ext_en,
   input wire logic [31:0] ext_lv,
   // Resolved pin levels
   output logic [31:0] pad_in
);
   logic wander_reg = 1'b0;
   // A line nobody drives or pulls wanders, so a stale level never reads as valid
   always @(posedge clk_sys) begin
      wander_reg <= ~wander_reg;
   end
   // Device driver first, then the board, then the pulls
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (pad_oe[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_en[i]) begin
            pad_in[i] = ext_lv[i];
         end else if (pad_pull_up[i] | pad_pull_down[i]) begin
            pad_in[i] = pad_pull_up[i];
         end else begin
            pad_in[i] = wander_reg;
         end
      end
   end
endmodule : pcfp_board

// ### tb/pcfp_port_asserts.sv
// Concurrent checks on the ports of the pad configuration and fast port block
`timescale 1ns/10ps
module pcfp_port_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reset_pin_n,
   // Local bus
   input wire logic lb_req,
   input wire logic lb_write,
   input wire logic [31:0] lb_addr,
   input wire logic lb_ack,
   input wire logic lb_err,
   // Function selection and tap side
   input wire logic [31:0] twi_sel,
   input wire logic [31:0] twi_drive_low,
   input wire logic [31:0] analog_sel,
   input wire logic scan_tdo,
   input wire logic scan_tdo_en,
   input wire logic scan_enable,
   input wire logic scan_tck,
   input wire logic scan_tms,
   input wire logic scan_tdi,
   // Pads
   input wire logic [31:0] pad_oe,
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_pull_up,
   input wire logic [31:0] pad_pull_down,
   input wire logic [63:0] pad_drive,
   input wire logic [31:0] pad_slew_limit
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // Bus answers: one cycle after each request, never otherwise
   ack_follows_req_a: assert property (lb_req |=> lb_ack)
      else $error("request not answered next cycle");
   ack_only_req_a: assert property (!lb_req |=> !lb_ack && !lb_err)
      else $error("answer without a request");
   pin_level_ro_a: assert property (lb_req && lb_addr == pcfp_pkg::ADDR_PIN_LEVEL
      |=> lb_err == $past(lb_write)) else $error("pin level access answered wrongly");
   alias_no_err_a: assert property (lb_req && lb_addr[31:5] == 27'h200001a
      && lb_addr[1:0] == 2'h0 |=> !lb_err) else $error("alias access refused");
   // Pad state right after release and while the reset pin is held
   reset_defaults_a: assert property ($fell(reset) |-> pad_oe == 32'h0
      && pad_pull_down == 32'h0 && pad_pull_up == 32'h1 && pad_drive == 64'h0)
      else $error("pad defaults wrong after reset");
   pin_low_pull_a: assert property (!reset_pin_n [*8] |=> pad_pull_up[0])
      else $error("test clock pull-up off while reset pin low");
   // Scan port pins: pulls on inputs, data out driven without pull
   scan_pins_a: assert property ($past(scan_enable) |-> pad_pull_up[2:0] == 3'h7
      && pad_oe[2:0] == 3'h0 && !pad_pull_up[3] && !pad_pull_down[3]
      && pad_oe[3] == $past(scan_tdo_en) && pad_out[3] == $past(scan_tdo))
      else $error("scan pin setup wrong");
   scan_off_idle_a: assert property (!scan_enable |-> scan_tck && scan_tms && scan_tdi)
      else $error("scan inputs not idle while port off");
   // Function overrides on plain lines
   analog_pulls_a: assert property (((pad_pull_up[31:4] | pad_pull_down[31:4])
      & $past(analog_sel[31:4])) == 28'h0) else $error("pull left on analog line");
   twi_drain_a: assert property ((pad_out[31:4] & $past(twi_sel[31:4] & ~analog_sel[31:4]))
      == 28'h0 && (pad_oe[31:4] & $past(twi_sel[31:4])) == $past(twi_drive_low[31:4]
      & twi_sel[31:4]) && (~pad_slew_limit[31:4] & $past(twi_sel[31:4])) == 28'h0)
      else $error("serial line not open drain");
endmodule : pcfp_port_asserts

bind pcfp_port pcfp_port_asserts u_asserts (.clk_sys, .reset, .reset_pin_n, .lb_req,
   .lb_write, .lb_addr, .lb_ack, .lb_err, .twi_sel, .twi_drive_low, .analog_sel, .scan_tdo,
   .scan_tdo_en, .scan_enable, .scan_tck, .scan_tms, .scan_tdi, .pad_oe, .pad_out,
   .pad_pull_up, .pad_pull_down, .pad_drive, .pad_slew_limit);

// ### tb/pcfp_port_tb.sv
// Self-checking bench for the pad configuration and fast port block
`timescale 1ns/10ps
module pcfp_port_tb;
   logic clk_sys = 1'b0, reset = 1'b1, reset_pin_n = 1'b0, lb_req = 1'b0, lb_write = 1'b0;
   logic cfg_we = 1'b0, scan_tdo = 1'b0, scan_tdo_en = 1'b0;
   logic [31:0] lb_addr = 32'h0, lb_wdata = 32'h0, ext_en = 32'h1, ext_lv = 32'h0;
   logic [31:0] periph_sel = 32'h0, periph_oe = 32'h0, periph_out = 32'h0;
   logic [31:0] twi_sel = 32'h0, twi_drive_low = 32'h0, analog_sel = 32'h0;
   logic [4:0] cfg_line = 5'h0;
   pcfp_pkg::pcfp_line_cfg_t cfg_wdata = 4'h0, cfg_rdata;
   logic lb_ack, lb_err, scan_enable, scan_tck, scan_tms, scan_tdi;
   logic [31:0] lb_rdata, pad_in, pad_oe, pad_out, pad_pull_up, pad_pull_down;
   logic [31:0] pad_slew_limit, pad_filter_en, oe_m, ov_m, wd, a;
   logic [63:0] pad_drive;
   logic [33:0] q[$];
   logic [33:0] e;
   logic [3:0] c;
   int seed = 20, n_mismatch = 0, checks_done = 0, cycles = 0, k;

   pcfp_port dut (.clk_sys, .reset, .reset_pin_n, .lb_req, .lb_write, .lb_addr, .lb_wdata,
      .lb_ack, .lb_err, .lb_rdata, .cfg_we, .cfg_line, .cfg_wdata, .cfg_rdata, .periph_sel,
      .periph_oe, .periph_out, .twi_sel, .twi_drive_low, .analog_sel, .scan_tdo, .scan_tdo_en,
      .scan_enable, .scan_tck, .scan_tms, .scan_tdi, .pad_in, .pad_oe, .pad_out, .pad_pull_up,
      .pad_pull_down, .pad_drive, .pad_slew_limit, .pad_filter_en);
   pcfp_board board (.clk_sys, .pad_oe, .pad_out, .pad_pull_up, .pad_pull_down, .ext_en,
      .ext_lv, .pad_in);

   // 25 MHz clock
   always #20 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task chk(input logic [63:0] x, input logic [63:0] y);
      checks_done++;
      if (x !== y) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, x, y);
      end
   endtask : chk
   // One-cycle request; the note is queued before the answer can arrive
   task bus(input logic w, input logic [31:0] ad, d, input logic er, input logic [31:0] r);
      @(posedge clk_sys);
      lb_req <= 1'b1;
      lb_write <= w;
      lb_addr <= ad;
      lb_wdata <= d;
      q.push_back({!w && !er, er, r});
      @(posedge clk_sys);
      lb_req <= 1'b0;
   endtask : bus
   function automatic logic [31:0] upd(input logic [31:0] cur, w, input logic [1:0] m);
      case (m)
         2'h0: upd = w;
         2'h1: upd = cur | w;
         2'h2: upd = cur & ~w;
         default: upd = cur ^ w;
      endcase
   endfunction : upd
   task summarize;
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   // Answer watcher retires the oldest note at each acknowledge
   always @(negedge clk_sys) begin
      if (lb_ack === 1'b1) begin
         e = q.size() > 0 ? q.pop_front() : 34'h0;
         checks_done++;
         if (lb_err !== e[32] || (e[33] && lb_rdata !== e[31:0])) begin
            n_mismatch++;
            $display("Error %0t: answer err %b data %h", $time, lb_err, lb_rdata);
         end
      end
   end
   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         $display("Error %0t: timeout", $time);
         summarize();
      end
   end
   ////////////////////////////////////////
   initial begin
      oe_m = pcfp_pkg::OE_RESET;
      ov_m = pcfp_pkg::OV_RESET;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({pad_oe, pad_pull_down}, 64'h0);
      chk(pad_pull_up, 64'h1);
      chk(pad_drive, 64'h0);
      $display("T1 reset defaults done");
      // Board holds the test clock low while the reset pin rises
      @(posedge clk_sys);
      reset_pin_n <= 1'b1; // pin released here, driven low again later for the second strap
      scan_tdo_en <= 1'b1;
      scan_tdo <= 1'b1;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(scan_enable, 64'h1);
      chk({pad_pull_up[3:0], pad_oe[3], pad_out[3]}, 64'h1f);
      chk({scan_tck, scan_tms, scan_tdi}, 64'h3);
      @(posedge clk_sys);
      reset_pin_n <= 1'b0;
      ext_en <= 32'h0;
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({scan_enable, pad_pull_up[0]}, 64'h1);
      @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      ext_en <= 32'hffff_ffff;
      ext_lv <= 32'h1; // Test clock high at release keeps the scan port off
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(scan_enable, 64'h0);
      $display("T2 scan strap done");
      // Every alias of both controls, with readback of the pins after each
      for (int i = 0; i < 8; i++) begin
         wd = $random(seed);
         a = (i < 4 ? pcfp_pkg::ADDR_OE_WRITE : pcfp_pkg::ADDR_OV_WRITE) + 32'(4 * (i % 4));
         bus(1'b1, a, wd, 1'b0, 32'h0);
         if (i < 4) oe_m = upd(oe_m, wd, 2'(i));
         else ov_m = upd(ov_m, wd, 2'(i));
         ext_lv <= $random(seed);
         repeat (6) @(posedge clk_sys);
         @(negedge clk_sys);
         chk({pad_oe, pad_out}, {oe_m, ov_m});
         bus(1'b0, a, 32'h0, 1'b0, 32'h0);
         bus(1'b0, pcfp_pkg::ADDR_PIN_LEVEL, 32'h0, 1'b0, (oe_m & ov_m) | (~oe_m & ext_lv));
      end
      bus(1'b1, pcfp_pkg::ADDR_PIN_LEVEL, 32'hffff_ffff, 1'b1, 32'h0);
      bus(1'b0, 32'h4000_0364, 32'h0, 1'b1, 32'h0);
      bus(1'b1, 32'h4000_0330, 32'hffff_ffff, 1'b1, 32'h0);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({pad_oe, pad_out}, {oe_m, ov_m});
      $display("T3 fast port aliases done");
      // Per-line pulls and drive, then the analog override
      for (int i = 0; i < 6; i++) begin
         k = 4 + 5 * i;
         c = 4'($random(seed));
         @(posedge clk_sys);
         cfg_we <= 1'b1;
         cfg_line <= 5'(k);
         cfg_wdata <= c;
         @(posedge clk_sys);
         cfg_we <= 1'b0;
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         chk(cfg_rdata, c);
         chk({pad_pull_up[k], pad_pull_down[k], pad_drive[2*k+:2]}, c);
         @(posedge clk_sys);
         analog_sel[k] <= 1'b1;
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         chk({pad_pull_up[k], pad_pull_down[k], pad_drive[2*k+:2]}, {2'h0, c[1:0]});
         @(posedge clk_sys);
         analog_sel[k] <= 1'b0;
      end
      $display("T4 line settings done");
      // Serial and peripheral functions beside plain lines
      @(posedge clk_sys);
      wd = $random(seed);
      twi_sel <= 32'hf0f0_f0f0;
      twi_drive_low <= wd;
      periph_sel <= 32'h0f0f_0f00;
      periph_oe <= ~wd;
      periph_out <= wd;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(pad_oe, (32'hf0f0_f0f0 & wd) | (32'h0f0f_0f00 & ~wd) | (32'hf & oe_m));
      chk(pad_out, (32'h0f0f_0f00 & wd) | (32'hf & ov_m));
      chk({pad_slew_limit, pad_filter_en}, {2{32'hf0f0_f0f0}});
      @(posedge clk_sys);
      twi_sel <= 32'h0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({pad_slew_limit, pad_oe & 32'hf0f0_f0f0}, {32'h0, oe_m & 32'hf0f0_f0f0});
      $display("T5 line functions done");
      chk(64'(q.size()), 64'h0);
      summarize();
   end
endmodule : pcfp_port_tb
